/* File: design/ccarr_top.sv */
// Sixteen-channel capture/compare array with two reloadable time bases.
// Assumes pins and external count inputs are asynchronous; all control is on ports.
// Function
// - Sixteen channels, one cycle resolution, staggered eight.
// - Two independent 16-bit timers with reload registers.
// - Timer clock from prescaler or timer six overflow.
// - Timers may count external input events.
// - Sixteen registers, timer and mode selectable each.
// - Each register owns one associated pin.
// - Capture copies assigned timer on pin event.
// - Each capture raises its own interrupt request.
// - Capture edge rising, falling or both.
// - Compare registers checked every cycle, or only in their slot when staggered, act on match.
// - Mode zero: interrupt only, repeats allowed.
// - Mode one: pin toggles on every match.
// - Mode two: one interrupt per timer period.
// - Mode three: set on match, clear on overflow.
// - Double mode: register pair toggles one pin.
// - Single event option stops after one action.
module ccarr_top (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic [1:0]   run_i,
  input  wire logic [3:0]   src_i,
  input  wire logic [5:0]   presc_i,
  input  wire logic [31:0]  reload_i,
  input  wire logic         gpt6_ovf_i,
  input  wire logic [1:0]   ext_cnt_i,
  input  wire logic         stagger_i,
  input  wire logic [47:0]  mode_i,
  input  wire logic [31:0]  edge_i,
  input  wire logic [15:0]  tsel_i,
  input  wire logic [15:0]  single_i,
  input  wire logic [15:0]  arm_i,
  input  wire logic [15:0]  wr_i,
  input  wire logic [255:0] wdata_i,
  input  wire logic [15:0]  pin_i,
  output logic      [15:0]  pin_o,
  output logic      [15:0]  pin_oe_o,
  output logic      [15:0]  irq_o,
  output logic      [255:0] cc_o,
  output logic      [31:0]  timer_o
);
  localparam int unsigned N = ccarr_pkg::NCH;

  // ==========================================================================
  // Input synchronisers: two flops before any logic reads a pin.
  logic [15:0] pin_s1, pin_s2, pin_d;
  logic [1:0]  ext_s1, ext_s2, ext_d;
  logic        g6_s1, g6_s2;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      pin_s1 <= 16'h0000;
      pin_s2 <= 16'h0000;
      pin_d  <= 16'h0000;
      ext_s1 <= 2'h0;
      ext_s2 <= 2'h0;
      ext_d  <= 2'h0;
      g6_s1  <= 1'b0;
      g6_s2  <= 1'b0;
    end else begin
      pin_s1 <= pin_i;
      pin_s2 <= pin_s1;
      pin_d  <= pin_s2;
      ext_s1 <= ext_cnt_i;
      ext_s2 <= ext_s1;
      ext_d  <= ext_s2;
      g6_s1  <= gpt6_ovf_i;
      g6_s2  <= g6_s1;
    end
  end

  // Timer six overflow arrives as a level pulse; take its rising edge once.
  logic g6_d;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) g6_d <= 1'b0;
    else          g6_d <= g6_s2;
  end

  // ==========================================================================
  // Prescaler and stagger slot counters.
  logic [7:0] presc_cnt, next_presc_cnt;
  logic [2:0] slot, next_slot;
  always_comb begin
    next_presc_cnt = presc_cnt + 8'h01;
    next_slot      = slot + 3'h1;
  end
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      presc_cnt <= ccarr_pkg::PRESC_RST;
      slot      <= 3'h0;
    end else begin
      presc_cnt <= next_presc_cnt;
      slot      <= next_slot;
    end
  end

  // ==========================================================================
  // The two time bases.
  logic [15:0] tval [2];
  logic [1:0]  tovf;
  for (genvar t = 0; t < 2; t++) begin : g_tmr
    ccarr_timer u_tmr (
      .clk_i        (clk_i),
      .rst_n_i      (rst_n_i),
      .run_i        (run_i[t]),
      .src_i        (src_i[2*t +: 2]),
      .presc_i      (presc_i[3*t +: 3]),
      .presc_cnt_i  (presc_cnt),
      .presc_tick_i (1'b1),
      .gpt6_ovf_i   (g6_s2 & ~g6_d),
      .ext_evt_i    (ext_s2[t] & ~ext_d[t]),
      .reload_i     (reload_i[16*t +: 16]),
      .value_o      (tval[t]),
      .ovf_o        (tovf[t])
    );
  end

  // Timer just stepped: true on the cycle after any timer update or overflow.
  logic [15:0] tprev [2];
  logic [1:0]  tstep;
  always_comb begin
    for (int t = 0; t < 2; t++) tstep[t] = (tval[t] != tprev[t]);
  end

  // ==========================================================================
  // Channel state: capture/compare register, pin latch, period lock, done flag.
  logic [15:0] cc [N];
  logic [15:0] next_cc [N];
  logic [15:0] pin_q, next_pin_q;
  logic [15:0] irq, next_irq;
  logic [15:0] lock, next_lock;
  logic [15:0] done, next_done;
  logic [15:0] pin_oe, next_pin_oe;

  // Channel action logic. In staggered mode a compare channel is only examined in its slot,
  // trading resolution (eight cycles) for less simultaneous switching on the pins.
  // A timer value may stay for several cycles under a prescaler, so a match is
  // acted on only in the cycle where the timer just changed, except in capture.
  always_comb begin
    logic [2:0]  m;
    logic [1:0]  e;
    logic [15:0] tv;
    logic        ovf, rise, fall, hit, en, cap, tgl;
    m = 3'h0; e = 2'h0; tv = 16'h0000;
    ovf = 1'b0; rise = 1'b0; fall = 1'b0; hit = 1'b0; en = 1'b0; cap = 1'b0; tgl = 1'b0;
    next_pin_q  = pin_q;
    next_irq    = 16'h0000;
    next_lock   = lock;
    next_done   = done & ~arm_i;  // Re-arming clears a finished single event.
    next_pin_oe = 16'h0000;
    for (int i = 0; i < N; i++) begin
      m    = mode_i[3*i +: 3];
      e    = edge_i[2*i +: 2];
      tv   = tval[tsel_i[i]];
      ovf  = tovf[tsel_i[i]];
      rise = pin_s2[i] & ~pin_d[i];
      fall = ~pin_s2[i] & pin_d[i];
      en   = !stagger_i || (slot == i[2:0]);
      hit  = en && tstep[tsel_i[i]] && (cc[i] == tv) && !done[i];
      next_cc[i] = cc[i];
      if (wr_i[i]) next_cc[i] = wdata_i[16*i +: 16];
      if (ovf) next_lock[i] = 1'b0;
      cap = ((e == ccarr_pkg::EDGE_RISE) && rise) ||
            ((e == ccarr_pkg::EDGE_FALL) && fall) ||
            ((e == ccarr_pkg::EDGE_BOTH) && (rise || fall));
      next_pin_oe[i] = (m != ccarr_pkg::MODE_CAPT) && (m != ccarr_pkg::MODE_OFF) &&
                       (m != ccarr_pkg::MODE_CMP0) && (m != ccarr_pkg::MODE_CMP2);
      case (m)
        ccarr_pkg::MODE_CAPT: begin
          if (cap) begin
            next_cc[i]  = tv;
            next_irq[i] = 1'b1;
          end
        end
        ccarr_pkg::MODE_CMP0: if (hit) next_irq[i] = 1'b1;
        ccarr_pkg::MODE_CMP1: begin
          if (hit) begin
            next_pin_q[i] = ~next_pin_q[i];
            next_irq[i]   = 1'b1;
          end
        end
        ccarr_pkg::MODE_CMP2: begin
          if (hit && !lock[i]) begin
            next_irq[i]  = 1'b1;
            next_lock[i] = 1'b1;
          end
        end
        ccarr_pkg::MODE_CMP3: begin
          if (hit && !lock[i]) begin
            next_pin_q[i] = 1'b1;
            next_irq[i]   = 1'b1;
            next_lock[i]  = 1'b1;
          end
          if (ovf) next_pin_q[i] = 1'b0;
        end
        ccarr_pkg::MODE_DOUBLE: begin
          // The lower channel of an even/odd pair drives the shared pin.
          tgl = hit;
          if (hit) next_irq[i] = 1'b1;
          if (tgl) next_pin_q[i & ~1] = ~next_pin_q[i & ~1];
          if (i[0]) next_pin_oe[i] = 1'b0;
          else      next_pin_oe[i] = 1'b1;
        end
        default: ;
      endcase
      if (hit && single_i[i] && (m != ccarr_pkg::MODE_CAPT)) next_done[i] = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < N; i++) cc[i] <= ccarr_pkg::CC_RST;
      tprev[0] <= ccarr_pkg::TIMER_RST;
      tprev[1] <= ccarr_pkg::TIMER_RST;
      pin_q    <= 16'h0000;
      irq      <= 16'h0000;
      lock     <= 16'h0000;
      done     <= 16'h0000;
      pin_oe   <= 16'h0000;
    end else begin
      for (int i = 0; i < N; i++) cc[i] <= next_cc[i];
      tprev[0] <= tval[0];
      tprev[1] <= tval[1];
      pin_q    <= next_pin_q;
      irq      <= next_irq;
      lock     <= next_lock;
      done     <= next_done;
      pin_oe   <= next_pin_oe;
    end
  end

  // ==========================================================================
  // Outputs, all from flops.
  logic [31:0] timer_q;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) timer_q <= 32'h0000_0000;
    else          timer_q <= {tval[1], tval[0]};
  end
  assign timer_o  = timer_q;
  assign pin_o    = pin_q;
  assign pin_oe_o = pin_oe;
  assign irq_o    = irq;
  for (genvar i = 0; i < N; i++) begin : g_cc
    assign cc_o[16*i +: 16] = cc[i];
  end
endmodule

/* File: design/ccarr_pkg.sv */
// Package of constants for the sixteen-channel capture/compare array.
// Assumes a single 20 MHz system clock and no register bus: all control is ports.
package ccarr_pkg;
  // ==========================================================================
  // Sizes
  localparam int unsigned NCH     = 16;
  localparam int unsigned TW      = 16;
  localparam int unsigned PSW     = 3;
  // ==========================================================================
  // Channel mode encoding (3 bits per channel).
  localparam logic [2:0] MODE_OFF    = 3'h0;
  localparam logic [2:0] MODE_CAPT   = 3'h1;
  localparam logic [2:0] MODE_CMP0   = 3'h2;
  localparam logic [2:0] MODE_CMP1   = 3'h3;
  localparam logic [2:0] MODE_CMP2   = 3'h4;
  localparam logic [2:0] MODE_CMP3   = 3'h5;
  localparam logic [2:0] MODE_DOUBLE = 3'h6;
  // Capture edge encoding.
  localparam logic [1:0] EDGE_NONE = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  // Timer clock source encoding.
  localparam logic [1:0] SRC_PRESC = 2'h0;
  localparam logic [1:0] SRC_GPT6  = 2'h1;
  localparam logic [1:0] SRC_EXT   = 2'h2;
  // ==========================================================================
  // Reset values and staggered timing.
  localparam logic [15:0] TIMER_RST   = 16'h0000;
  localparam logic [15:0] CC_RST      = 16'h0000;
  localparam logic [2:0]  STAGGER_MAX = 3'h7;  // Eight slots, one per cycle.
  localparam logic [7:0]  PRESC_RST   = 8'h00;
endpackage

/* File: design/ccarr_timer.sv */
// One 16-bit reloadable time base of the capture/compare array.
// Assumes count sources are already synchronised one-cycle pulses or levels.
module ccarr_timer (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        run_i,
  input  wire logic [1:0]  src_i,
  input  wire logic [2:0]  presc_i,
  input  wire logic [7:0]  presc_cnt_i,
  input  wire logic        presc_tick_i,
  input  wire logic        gpt6_ovf_i,
  input  wire logic        ext_evt_i,
  input  wire logic [15:0] reload_i,
  output logic      [15:0] value_o,
  output logic             ovf_o
);
  logic [15:0] value;
  logic [15:0] next_value;
  logic        ovf;
  logic        next_ovf;
  logic        tick;

  // ==========================================================================
  // Count step selection and reload.
  // A prescale of n advances once every 2**n system cycles.
  always_comb begin
    case (src_i)
      ccarr_pkg::SRC_PRESC: tick = presc_tick_i &&
        ((presc_cnt_i & ((8'h01 << presc_i) - 8'h01)) == 8'h00);
      ccarr_pkg::SRC_GPT6:  tick = gpt6_ovf_i;
      ccarr_pkg::SRC_EXT:   tick = ext_evt_i;
      default:              tick = 1'b0;
    endcase
    next_value = value;
    next_ovf   = 1'b0;
    if (run_i && tick) begin
      if (value == 16'hFFFF) begin
        next_value = reload_i;
        next_ovf   = 1'b1;
      end else begin
        next_value = value + 16'h0001;
      end
    end
  end

  // Registers only.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      value <= ccarr_pkg::TIMER_RST;
      ovf   <= 1'b0;
    end else begin
      value <= next_value;
      ovf   <= next_ovf;
    end
  end

  assign value_o = value;
  assign ovf_o   = ovf;
endmodule

/* File: sim/ccarr_monitor.sv */
// Port checker for the capture/compare array.
// Assumes it is bound to ccarr_top and sees only its ports.
module ccarr_monitor (
  input wire logic         clk_i,
  input wire logic         rst_n_i,
  input wire logic [1:0]   run_i,
  input wire logic [3:0]   src_i,
  input wire logic [5:0]   presc_i,
  input wire logic [47:0]  mode_i,
  input wire logic [15:0]  tsel_i,
  input wire logic [15:0]  pin_o,
  input wire logic [15:0]  pin_oe_o,
  input wire logic [15:0]  irq_o,
  input wire logic [255:0] cc_o,
  input wire logic [31:0]  timer_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================================
  // Checks
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  logic [15:0] t0;
  // Timer zero alone, to keep the compare checks short.
  assign t0 = timer_o[15:0];
  AST_RST_QUIET: assert property ($rose(rst_n_i) |-> !irq_o && !timer_o)
    else $error("outputs not clear after reset");
  AST_RUN_HOLD: assert property (!run_i[0] [*3] |-> $stable(t0))
    else $error("stopped timer moved");
  AST_PRESC_STEP: assert property ((run_i[0] && !src_i[1:0] && !presc_i[2:0]) [*3]
    |-> $changed(t0)) else $error("timer missed a step");
  AST_OFF_QUIET: assert property ((mode_i[2:0] == 3'h0) [*5] |-> !irq_o[0])
    else $error("idle channel raised irq");
  AST_CAPT_INPUT: assert property ((mode_i[5:3] == 3'h1) [*2] |-> !pin_oe_o[1])
    else $error("capture pin driven");
  AST_CMP0_PIN: assert property ((mode_i[8:6] == 3'h2) [*2] |-> $stable(pin_o[2]))
    else $error("mode zero moved its pin");
  AST_IRQ_PULSE: assert property (irq_o[2] && mode_i[8:6] != 3'h1 |=> !irq_o[2])
    else $error("irq longer than one cycle");
  AST_CMP1_MATCH: assert property ((mode_i[2:0] == 3'h3 && !tsel_i[0]) [*4]
    ##0 $changed(pin_o[0]) |-> t0 == cc_o[15:0] || $past(t0) == cc_o[15:0])
    else $error("toggle without match");
  AST_CMP3_CLEAR: assert property ((mode_i[11:9] == 3'h5 && !tsel_i[3]) [*4]
    ##0 $fell(pin_o[3]) |-> $past(t0) == 16'hFFFF || $past(t0, 2) == 16'hFFFF)
    else $error("clear without overflow");
endmodule
bind ccarr_top ccarr_monitor mon_u (.clk_i, .rst_n_i, .run_i, .src_i, .presc_i, .mode_i,
  .tsel_i, .pin_o, .pin_oe_o, .irq_o, .cc_o, .timer_o);

/* File: sim/ccarr_pins.sv */
// Far side of the array: loads on the pins and the external count inputs.
// Assumes the bench calls its tasks; lines change only at rising edges.
module ccarr_pins (
  input  wire logic        clk_i,
  input  wire logic [15:0] pin_o,
  input  wire logic [15:0] pin_oe_o,
  output logic      [15:0] pin_i,
  output logic      [1:0]  ext_cnt_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] drv = 16'h0000;
  // ==========================================================================
  // The device wins the wire while it drives, else the far side's level shows.
  assign pin_i = (pin_oe_o & pin_o) | (~pin_oe_o & drv);
  initial ext_cnt_o = 2'h0;
  task automatic set_pin(input int ch, input logic v);
    @(posedge clk_i);
    drv[ch] <= v;
  endtask
  // Pulses last four cycles each way so the two-flop synchroniser cannot miss them.
  task automatic ext_pulses(input int idx, input int n);
    repeat (n) begin
      repeat (4) @(posedge clk_i);
      ext_cnt_o[idx] <= 1'b1;
      repeat (4) @(posedge clk_i);
      ext_cnt_o[idx] <= 1'b0;
    end
  endtask
endmodule

/* File: sim/tb.sv */
// Self-checking bench for the capture/compare array.
// Assumes ccarr_top, its package and the pin model are compiled first.
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic           clk_i = 1'b0;
  logic           rst_n_i = 1'b0;
  logic [1:0]     run_i = 2'h0;
  logic [3:0]     src_i = 4'h0;
  logic           gpt6_ovf_i = 1'b0;
  logic           stagger_i = 1'b0;
  logic [5:0]     presc_i = 6'h00;
  logic [31:0]    reload_i = 32'h0000_0000;
  logic [47:0]    mode_i = 48'h0;
  logic [31:0]    edge_i = 32'h0;
  logic [15:0]    tsel_i = 16'h0;
  logic [15:0]    single_i = 16'h0;
  logic [15:0]    arm_i = 16'h0;
  logic [15:0]    wr_i = 16'h0;
  logic [255:0]   wdata_i = 256'h0;
  logic [15:0]    pin_i, pin_o, pin_oe_o, irq_o;
  logic [1:0]     ext_cnt_i;
  logic [255:0]   cc_o;
  logic [31:0]    timer_o;
  int             error_cnt = 0;
  int             check_count = 0;
  // ==========================================================================
  // Clock, design and far side.
  always #25 clk_i = ~clk_i;
  ccarr_top dut_u (.clk_i, .rst_n_i, .run_i, .src_i, .presc_i, .reload_i, .gpt6_ovf_i,
    .ext_cnt_i, .stagger_i, .mode_i, .edge_i, .tsel_i, .single_i, .arm_i, .wr_i,
    .wdata_i, .pin_i, .pin_o, .pin_oe_o, .irq_o, .cc_o, .timer_o);
  ccarr_pins pins_u (.clk_i, .pin_o, .pin_oe_o, .pin_i, .ext_cnt_o(ext_cnt_i));
  // ==========================================================================
  // Shared tasks.
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic ok, input string m);
    check_count++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("MISMATCH t=%0t %s", $time, m);
    end
  endtask
  task automatic cnt_irq(input int ch, input int cyc, output int n);
    n = 0;
    repeat (cyc) begin
      @(posedge clk_i);
      #1 if (irq_o[ch] === 1'b1) n++;
    end
  endtask
  // A wait that runs out counts as a mismatch and ends the run at once.
  task automatic wait_pin(input int ch, input logic v);
    int i = 0;
    while (pin_o[ch] !== v) begin
      @(posedge clk_i);
      #1 i++;
      if (i > 70000) begin
        chk(1'b0, "wait ran out");
        wrap_up();
      end
    end
  endtask
  task automatic hi_time(input int ch, output int n);
    wait_pin(ch, 1'b0);
    wait_pin(ch, 1'b1);
    n = 0;
    while (pin_o[ch] === 1'b1 && n < 100) begin
      @(posedge clk_i);
      #1 n++;
    end
  endtask
  task automatic wr(input int ch, input logic [15:0] v);
    @(posedge clk_i);
    wr_i[ch] <= 1'b1;
    wdata_i[16*ch +: 16] <= v;
    @(posedge clk_i);
    wr_i[ch] <= 1'b0;
  endtask
  // Waits for a match on channel two, moves its register later in the same period, then counts.
  task automatic retarget(input logic [15:0] v, output int n);
    int i;
    i = 0;
    while (irq_o[2] !== 1'b1) begin
      @(posedge clk_i);
      #1 i++;
      if (i > 40) begin
        chk(1'b0, "match wait ran out");
        wrap_up();
      end
    end
    wr(2, v);
    cnt_irq(2, 8, n);
  endtask
  // ==========================================================================
  // Scenarios.
  task automatic t_capture();
    int n;
    @(posedge clk_i);
    mode_i[5:3] <= ccarr_pkg::MODE_CAPT;
    edge_i[3:2] <= ccarr_pkg::EDGE_RISE;
    tsel_i[1] <= 1'b1;
    src_i[3:2] <= ccarr_pkg::SRC_EXT;
    run_i[1] <= 1'b1;
    pins_u.ext_pulses(1, 5);
    repeat (4) @(posedge clk_i);
    #1 chk(timer_o[31:16] === 16'h0005, "external count");
    pins_u.set_pin(1, 1'b1);
    cnt_irq(1, 8, n);
    chk(n == 1, "capture irq");
    chk(cc_o[31:16] === 16'h0005, "captured value");
    $display("capture test done");
  endtask
  // Pin falls then rises under each edge choice; expected irq counts 0, 1, 1, 2.
  task automatic t_edges();
    int a, b;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_i);
      edge_i[3:2] <= i[1:0];
      pins_u.set_pin(1, 1'b0);
      cnt_irq(1, 8, a);
      pins_u.set_pin(1, 1'b1);
      cnt_irq(1, 8, b);
      chk(a == i[1] && b == i[0], "edge count");
    end
    $display("edge test done");
  endtask
  // Timer zero reloads to FFF0, so every compare channel repeats each 16 cycles.
  task automatic t_compare();
    int n;
    wr(0, 16'hFFF8);
    wr(2, 16'hFFF4);
    wr(3, 16'hFFF8);
    wr(4, 16'hFFF2);
    wr(5, 16'hFFF6);
    @(posedge clk_i);
    mode_i[17:6] <= {3'h6, 3'h6, ccarr_pkg::MODE_CMP3, ccarr_pkg::MODE_CMP0};
    mode_i[2:0] <= ccarr_pkg::MODE_CMP1;
    reload_i[15:0] <= 16'hFFF0;
    run_i[0] <= 1'b1;
    hi_time(0, n);
    chk(n == 16 && pin_oe_o[0] === 1'b1, "toggle spacing");
    hi_time(3, n);
    chk(n == 8, "set until overflow");
    hi_time(4, n);
    chk(n == 4, "pair toggle");
    cnt_irq(2, 48, n);
    chk(n == 3, "mode zero repeats");
    retarget(16'hFFFC, n);
    chk(n == 1, "mode zero second match");
    wr(2, 16'hFFF4);
    @(posedge clk_i);
    mode_i[8:6] <= ccarr_pkg::MODE_CMP2;
    cnt_irq(2, 48, n);
    chk(n == 3, "one irq per period");
    retarget(16'hFFFC, n);
    chk(n == 0, "second match locked out");
    @(posedge clk_i);
    single_i[2] <= 1'b1;
    arm_i[2] <= 1'b1;
    @(posedge clk_i);
    arm_i[2] <= 1'b0;
    cnt_irq(2, 64, n);
    chk(n == 1, "single event");
    @(posedge clk_i);
    arm_i[2] <= 1'b1;
    @(posedge clk_i);
    arm_i[2] <= 1'b0;
    cnt_irq(2, 32, n);
    chk(n == 1, "re-armed single event");
    $display("compare test done");
  endtask
  // Timer one: timer six edges, then prescale of eight, then staggered slots.
  // Slot and prescaler count together, so a step of timer one lands in slot one.
  task automatic t_sources();
    int          a, b;
    logic [15:0] v;
    @(posedge clk_i);
    src_i[3:2] <= ccarr_pkg::SRC_GPT6;
    repeat (3) begin
      repeat (4) @(posedge clk_i);
      gpt6_ovf_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      gpt6_ovf_i <= 1'b0;
    end
    repeat (4) @(posedge clk_i);
    #1 chk(timer_o[31:16] === 16'h0008, "timer six count");
    @(posedge clk_i);
    src_i[3:2] <= ccarr_pkg::SRC_PRESC;
    presc_i[5:3] <= 3'h3;
    repeat (3) @(posedge clk_i);
    #1 v = timer_o[31:16];
    repeat (40) @(posedge clk_i);
    #1 chk(timer_o[31:16] - v === 16'h0005, "prescaled step");
    @(posedge clk_i);
    stagger_i <= 1'b1;
    #1 v = timer_o[31:16] + 16'h0003;
    wr(9, v);
    wr(6, v);
    @(posedge clk_i);
    tsel_i[9] <= 1'b1;
    tsel_i[6] <= 1'b1;
    mode_i[29:27] <= ccarr_pkg::MODE_CMP0;
    mode_i[20:18] <= ccarr_pkg::MODE_CMP0;
    a = 0;
    b = 0;
    repeat (40) begin
      @(posedge clk_i);
      #1 a += irq_o[9];
      b += irq_o[6];
    end
    chk(a == 1 && b == 0, "staggered slots");
    $display("source test done");
  endtask
  initial begin
    repeat (12) @(posedge clk_i);
    rst_n_i <= 1'b1;
    #1 chk(timer_o === 32'h0 && irq_o === 16'h0, "reset state");
    t_capture();
    t_edges();
    t_compare();
    t_sources();
    wrap_up();
  end
endmodule
